// file: core/fts_space_map_top.sv
`timescale 1ns/1ps
module fts_space_map_top
  import fts_pkg::*;
#(
  parameter fts_map_mode_t MAP_MODE = FTS_MAP_PROGRAMMABLE,
  parameter bit DOWNSTREAM_PARTITION = 1'b1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [FTS_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [1:0] s_axi_awpas,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [FTS_ADDR_W-1:0] s_axi_araddr,
  input wire logic [1:0] s_axi_arpas,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic req_valid,
  input wire logic [1:0] request_space_label,
  input wire logic [1:0] req_pas,
  input wire logic [FTS_PID_W-1:0] req_partition_identifier,
  input wire logic [FTS_PMG_W-1:0] req_pmg,
  output logic fwd_valid,
  output logic [1:0] fwd_pas,
  output logic request_nonsecure_label,
  output logic suppress_monitor_flag,
  output logic [FTS_PID_W-1:0] fwd_partition_identifier,
  output logic [FTS_PMG_W-1:0] fwd_pmg
);

  logic [15:0] space_map_control_q;
  logic [31:0] remap_cnt_q;
  logic [31:0] suppr_cnt_q;
  logic aw_got_q;
  logic aw_got_d;
  logic [FTS_ADDR_W-1:0] aw_addr_q;
  logic [1:0] aw_pas_q;
  logic w_got_q;
  logic w_got_d;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic aw_take;
  logic w_take;
  logic wr_fire;
  logic [1:0] wr_resp;
  logic bvalid_d;
  logic ar_take;
  logic rvalid_d;
  logic [1:0] rd_resp;
  logic [31:0] rd_word;
  logic map_ns;
  logic map_nomon;

  fts_space_mapper #(
    .MAP_MODE(MAP_MODE)
  ) u_mapper (
    .space_label(request_space_label),
    .map_ctrl(space_map_control_q),
    .nonsecure_label(map_ns),
    .suppress_monitor(map_nomon)
  );

  // Write channel: address and data taken in either order, one write in flight
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign wr_fire = aw_got_q & w_got_q & ~s_axi_bvalid;
  assign aw_got_d = aw_take | (aw_got_q & ~wr_fire);
  assign w_got_d = w_take | (w_got_q & ~wr_fire);
  assign bvalid_d = wr_fire | (s_axi_bvalid & ~s_axi_bready);
  assign wr_resp = fts_resp(aw_addr_q, aw_pas_q);

  always_ff @(posedge clock) begin
    if (rst) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      aw_addr_q <= FTS_ADDR_CTRL;
      aw_pas_q <= FTS_SP_SECURE;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      s_axi_awready <= ~aw_got_d & ~bvalid_d;
      s_axi_wready <= ~w_got_d & ~bvalid_d;
      if (aw_take) begin
        aw_addr_q <= s_axi_awaddr;
        aw_pas_q <= s_axi_awpas;
      end
      if (w_take) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= FTS_RESP_OKAY;
    end else begin
      s_axi_bvalid <= bvalid_d;
      if (wr_fire) begin
        s_axi_bresp <= wr_resp;
      end
    end
  end

  // Only a Root-space write reaches the control bits; others get SLVERR
  always_ff @(posedge clock) begin
    if (rst) begin
      space_map_control_q <= FTS_CTRL_RESET;
    end else if (wr_fire && wr_resp == FTS_RESP_OKAY && aw_addr_q == FTS_ADDR_CTRL) begin
      space_map_control_q <= fts_merge(space_map_control_q, w_data_q[15:0], w_strb_q[1:0]);
    end
  end

  // Read channel
  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign rvalid_d = ar_take | (s_axi_rvalid & ~s_axi_rready);
  assign rd_resp = fts_resp(s_axi_araddr, s_axi_arpas);

  always_comb begin
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      FTS_ADDR_CTRL: begin
        rd_word = {16'h0000, space_map_control_q};
      end
      FTS_ADDR_REMAP_CNT: begin
        rd_word = remap_cnt_q;
      end
      FTS_ADDR_SUPPR_CNT: begin
        rd_word = suppr_cnt_q;
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= FTS_RESP_OKAY;
    end else begin
      s_axi_arready <= ~rvalid_d;
      s_axi_rvalid <= rvalid_d;
      if (ar_take) begin
        s_axi_rresp <= rd_resp;
        // Non-Root readers see zeros, never the mapping
        s_axi_rdata <= (rd_resp == FTS_RESP_OKAY) ? rd_word : 32'h0000_0000;
      end
    end
  end

  // Request path: one register stage, every request forwarded
  always_ff @(posedge clock) begin
    if (rst) begin
      fwd_valid <= 1'b0;
      fwd_pas <= FTS_SP_SECURE;
      request_nonsecure_label <= 1'b0;
      suppress_monitor_flag <= 1'b0;
      fwd_partition_identifier <= '0;
      fwd_pmg <= '0;
    end else begin
      fwd_valid <= req_valid;
      fwd_pas <= req_pas;
      if (DOWNSTREAM_PARTITION) begin
        request_nonsecure_label <= map_ns;
        // Flag gated by valid; harmless to leave open downstream
        suppress_monitor_flag <= req_valid & map_nomon;
        fwd_partition_identifier <= req_partition_identifier;
        fwd_pmg <= req_pmg;
      end else begin
        request_nonsecure_label <= 1'b0;
        suppress_monitor_flag <= 1'b0;
        fwd_partition_identifier <= '0;
        fwd_pmg <= '0;
      end
    end
  end

  // Wrapping counters: software takes differences, no clear needed
  always_ff @(posedge clock) begin
    if (rst) begin
      remap_cnt_q <= FTS_CNT_RESET;
      suppr_cnt_q <= FTS_CNT_RESET;
    end else begin
      if (req_valid && request_space_label[1]) begin
        remap_cnt_q <= remap_cnt_q + 32'h0000_0001;
      end
      if (req_valid && map_nomon && DOWNSTREAM_PARTITION) begin
        suppr_cnt_q <= suppr_cnt_q + 32'h0000_0001;
      end
    end
  end

  localparam bit PROG_LIVE = (MAP_MODE == FTS_MAP_PROGRAMMABLE) && DOWNSTREAM_PARTITION;

  sequence seq_root_req;
    req_valid && request_space_label == FTS_SP_ROOT;
  endsequence

  sequence seq_realm_req;
    req_valid && request_space_label == FTS_SP_REALM;
  endsequence

  sequence seq_write_ready;
    aw_got_q && w_got_q && !s_axi_bvalid;
  endsequence

  sequence seq_write_done;
    ##1 s_axi_bvalid;
  endsequence

  chk_root_space_out: assert property (@(posedge clock) disable iff (rst)
    (seq_root_req and PROG_LIVE) |=> request_nonsecure_label == $past(space_map_control_q[FTS_ROOT_SPACE_BIT]))
    else $error("Root request label not taken from control");

  chk_root_nomon_out: assert property (@(posedge clock) disable iff (rst)
    (seq_root_req and PROG_LIVE) |=> suppress_monitor_flag == $past(space_map_control_q[FTS_ROOT_NOMON_BIT]))
    else $error("Root request flag not taken from control");

  chk_realm_space_out: assert property (@(posedge clock) disable iff (rst)
    (seq_realm_req and PROG_LIVE) |=> request_nonsecure_label == $past(space_map_control_q[FTS_REALM_SPACE_BIT]))
    else $error("Realm request label not taken from control");

  chk_realm_nomon_out: assert property (@(posedge clock) disable iff (rst)
    (seq_realm_req and PROG_LIVE) |=> suppress_monitor_flag == $past(space_map_control_q[FTS_REALM_NOMON_BIT]))
    else $error("Realm request flag not taken from control");

  chk_every_req_fwd: assert property (@(posedge clock) disable iff (rst)
    req_valid |=> fwd_valid)
    else $error("Request was not forwarded");

  chk_ctrl_root_only: assert property (@(posedge clock) disable iff (rst)
    seq_write_ready and (aw_pas_q != FTS_SP_ROOT) |=> $stable(space_map_control_q) && s_axi_bvalid
      && s_axi_bresp != FTS_RESP_OKAY)
    else $error("Non-Root write reached the control register");

  chk_read_non_root: assert property (@(posedge clock) disable iff (rst)
    s_axi_arvalid && s_axi_arready && s_axi_arpas != FTS_SP_ROOT |=> s_axi_rvalid && s_axi_rdata == 32'h0000_0000)
    else $error("Non-Root read returned data");

  chk_write_answers: assert property (@(posedge clock) disable iff (rst)
    seq_write_ready |-> seq_write_done)
    else $error("Write response missing one cycle after both halves");

  chk_bvalid_held: assert property (@(posedge clock) disable iff (rst)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response dropped before taken");

  chk_fixed_bit0: assert property (@(posedge clock) disable iff (rst)
    MAP_MODE == FTS_MAP_FIXED && DOWNSTREAM_PARTITION && req_valid
      |=> request_nonsecure_label == $past(request_space_label[0]) && !suppress_monitor_flag)
    else $error("Fixed reduction did not pass bit 0");

  chk_no_partition: assert property (@(posedge clock) disable iff (rst)
    !DOWNSTREAM_PARTITION |-> fwd_partition_identifier == '0 && fwd_pmg == '0 && !suppress_monitor_flag)
    else $error("Partition information leaked downstream");

  chk_two_space_kept: assert property (@(posedge clock) disable iff (rst)
    DOWNSTREAM_PARTITION && req_valid && !request_space_label[1]
      |=> request_nonsecure_label == $past(request_space_label[0]))
    else $error("Secure or Non-secure request changed space");

  chk_pas_kept: assert property (@(posedge clock) disable iff (rst)
    req_valid |=> fwd_pas == $past(req_pas))
    else $error("Physical address space altered");

  chk_nomon_low: assert property (@(posedge clock) disable iff (rst)
    req_valid && !request_space_label[1] |=> !suppress_monitor_flag)
    else $error("Flag raised on a two-space request");

  chk_ctrl_reserved: assert property (@(posedge clock) disable iff (rst)
    (space_map_control_q & ~FTS_CTRL_MASK) == 16'h0000)
    else $error("Reserved control bits set");

  chk_flag_needs_valid: assert property (@(posedge clock) disable iff (rst)
    suppress_monitor_flag |-> fwd_valid)
    else $error("Flag raised without a forwarded request");

  chk_root_ctrl_read: assert property (@(posedge clock) disable iff (rst)
    s_axi_arvalid && s_axi_arready && s_axi_arpas == FTS_SP_ROOT && s_axi_araddr == FTS_ADDR_CTRL
      |=> s_axi_rresp == FTS_RESP_OKAY && s_axi_rdata == {16'h0000, $past(space_map_control_q)})
    else $error("Root read of control returned wrong word");

  chk_root_write_ok: assert property (@(posedge clock) disable iff (rst)
    seq_write_ready and (aw_pas_q == FTS_SP_ROOT) and (aw_addr_q == FTS_ADDR_CTRL)
      |=> s_axi_bvalid && s_axi_bresp == FTS_RESP_OKAY)
    else $error("Root write to control refused");

endmodule

// file: core/fts_pkg.sv
package fts_pkg;

  typedef enum logic [1:0] {
    FTS_MAP_PROGRAMMABLE = 2'h1,
    FTS_MAP_FIXED = 2'h2
  } fts_map_mode_t;

  localparam int FTS_ADDR_W = 12;
  localparam int FTS_PID_W = 16;
  localparam int FTS_PMG_W = 8;

  // Space label encoding, shared by request labels and bus access spaces
  localparam logic [1:0] FTS_SP_SECURE = 2'h0;
  localparam logic [1:0] FTS_SP_NONSECURE = 2'h1;
  localparam logic [1:0] FTS_SP_ROOT = 2'h2;
  localparam logic [1:0] FTS_SP_REALM = 2'h3;

  localparam int FTS_ROOT_SPACE_BIT = 15;
  localparam int FTS_ROOT_NOMON_BIT = 14;
  localparam int FTS_REALM_SPACE_BIT = 7;
  localparam int FTS_REALM_NOMON_BIT = 6;
  localparam logic [15:0] FTS_CTRL_MASK = 16'hC0C0;
  localparam logic [15:0] FTS_CTRL_RESET = 16'h0000;
  localparam logic [31:0] FTS_CNT_RESET = 32'h0000_0000;

  localparam logic [FTS_ADDR_W-1:0] FTS_ADDR_CTRL = 12'h000;
  localparam logic [FTS_ADDR_W-1:0] FTS_ADDR_REMAP_CNT = 12'h004;
  localparam logic [FTS_ADDR_W-1:0] FTS_ADDR_SUPPR_CNT = 12'h008;

  localparam logic [1:0] FTS_RESP_OKAY = 2'h0;
  localparam logic [1:0] FTS_RESP_SLVERR = 2'h2;
  localparam logic [1:0] FTS_RESP_DECERR = 2'h3;

  function automatic logic fts_mapped(input logic [FTS_ADDR_W-1:0] addr);
    return (addr == FTS_ADDR_CTRL) || (addr == FTS_ADDR_REMAP_CNT) || (addr == FTS_ADDR_SUPPR_CNT);
  endfunction

  // Unmapped wins over the space check so software can probe the map
  function automatic logic [1:0] fts_resp(input logic [FTS_ADDR_W-1:0] addr, input logic [1:0] pas);
    if (!fts_mapped(addr)) begin
      return FTS_RESP_DECERR;
    end
    if (pas != FTS_SP_ROOT) begin
      return FTS_RESP_SLVERR;
    end
    return FTS_RESP_OKAY;
  endfunction

  function automatic logic [15:0] fts_merge(input logic [15:0] old_val, input logic [15:0] new_val,
                                            input logic [1:0] strb);
    logic [15:0] res;
    res = old_val;
    if (strb[0]) begin
      res[7:0] = new_val[7:0];
    end
    if (strb[1]) begin
      res[15:8] = new_val[15:8];
    end
    return res & FTS_CTRL_MASK;
  endfunction

endpackage

// file: core/fts_space_mapper.sv
`timescale 1ns/1ps
module fts_space_mapper
  import fts_pkg::*;
#(
  parameter fts_map_mode_t MAP_MODE = FTS_MAP_PROGRAMMABLE
) (
  input wire logic [1:0] space_label,
  input wire logic [15:0] map_ctrl,
  output logic nonsecure_label,
  output logic suppress_monitor
);

  always_comb begin
    nonsecure_label = space_label[0];
    suppress_monitor = 1'b0;
    if (MAP_MODE == FTS_MAP_FIXED) begin
      // Cheapest variant: Root folds to Secure, Realm to Non-secure
      nonsecure_label = space_label[0];
      suppress_monitor = 1'b0;
    end else begin
      case (space_label)
        FTS_SP_ROOT: begin
          nonsecure_label = map_ctrl[FTS_ROOT_SPACE_BIT];
          suppress_monitor = map_ctrl[FTS_ROOT_NOMON_BIT];
        end
        FTS_SP_REALM: begin
          nonsecure_label = map_ctrl[FTS_REALM_SPACE_BIT];
          suppress_monitor = map_ctrl[FTS_REALM_NOMON_BIT];
        end
        FTS_SP_SECURE, FTS_SP_NONSECURE: begin
          nonsecure_label = space_label[0];
          suppress_monitor = 1'b0;
        end
        default: begin
          nonsecure_label = space_label[0];
          suppress_monitor = 1'b0;
        end
      endcase
    end
  end

endmodule

// file: dv/fts_msc_model.sv
`timescale 1ns/1ps
module fts_msc_model #(
  parameter bit HAS_FLAG = 1'b1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic fwd_valid,
  input wire logic suppress_monitor,
  output int unsigned n_seen,
  output int unsigned n_monitored
);
  // Without the flag input every request lands in the monitors
  always_ff @(posedge clock) begin
    if (rst) begin
      n_seen <= 0;
      n_monitored <= 0;
    end else if (fwd_valid) begin
      n_seen <= n_seen + 1;
      if (!(HAS_FLAG && suppress_monitor)) begin
        n_monitored <= n_monitored + 1;
      end
    end
  end
endmodule

// file: dv/four_to_two_space_mapper_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; $display("BAD %s exp %h got %h", nm, e, g); end end
module four_to_two_space_mapper_tb
  import fts_pkg::*;
;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;
  int exp_mon = 0;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, req_valid;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [FTS_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [1:0] s_axi_awpas, s_axi_arpas, s_axi_bresp, s_axi_rresp, request_space_label, req_pas, fwd_pas, resp;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [FTS_PID_W-1:0] req_partition_identifier, fwd_partition_identifier, np_pid;
  logic [FTS_PMG_W-1:0] req_pmg, fwd_pmg, np_pmg;
  logic fwd_valid, request_nonsecure_label, suppress_monitor_flag, fx_ns, fx_flag, np_flag;
  int unsigned n_seen, n_monitored;

  always #5 clock = ~clock;

  fts_space_map_top fts_space_map_top_inst (.*);
  fts_space_map_top #(.MAP_MODE(FTS_MAP_FIXED)) fts_space_map_top_fixed_inst (.*, .s_axi_awready(), .s_axi_wready(),
    .s_axi_bvalid(), .s_axi_bresp(), .s_axi_arready(), .s_axi_rvalid(), .s_axi_rdata(), .s_axi_rresp(),
    .fwd_valid(), .fwd_pas(), .request_nonsecure_label(fx_ns), .suppress_monitor_flag(fx_flag),
    .fwd_partition_identifier(), .fwd_pmg());
  fts_space_map_top #(.DOWNSTREAM_PARTITION(1'b0)) fts_space_map_top_nopart_inst (.*, .s_axi_awready(),
    .s_axi_wready(), .s_axi_bvalid(), .s_axi_bresp(), .s_axi_arready(), .s_axi_rvalid(), .s_axi_rdata(),
    .s_axi_rresp(), .fwd_valid(), .fwd_pas(), .request_nonsecure_label(), .suppress_monitor_flag(np_flag),
    .fwd_partition_identifier(np_pid), .fwd_pmg(np_pmg));
  fts_msc_model fts_msc_model_inst (.clock(clock), .rst(rst), .fwd_valid(fwd_valid),
    .suppress_monitor(suppress_monitor_flag), .n_seen(n_seen), .n_monitored(n_monitored));

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Whole run needs about 140 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      summarize();
    end
  end

  task automatic axw(input logic [11:0] a, input logic [1:0] p, input logic [31:0] d, input logic [3:0] s = 4'hF);
    @(posedge clock);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_awpas <= p;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axr(input logic [11:0] a, input logic [1:0] p);
    @(posedge clock);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_arpas <= p;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Returns {label, flag} the bridge should emit
  function automatic logic [1:0] exp_map(input logic [1:0] l, input logic [15:0] c);
    case (l)
      FTS_SP_ROOT: return {c[15], c[14]};
      FTS_SP_REALM: return {c[7], c[6]};
      default: return {l[0], 1'b0};
    endcase
  endfunction

  task automatic t_regs();
    axr(FTS_ADDR_CTRL, FTS_SP_ROOT);
    `CHK("ctrl reset", 32'h0000_0000, rd)
    `CHK("root rd resp", FTS_RESP_OKAY, resp)
    axw(FTS_ADDR_CTRL, FTS_SP_ROOT, 32'hFFFF_FFFF);
    `CHK("root wr resp", FTS_RESP_OKAY, resp)
    axr(FTS_ADDR_CTRL, FTS_SP_ROOT);
    `CHK("ctrl mask", 32'h0000_C0C0, rd)
    // Lane strobes: only the strobed byte may change
    axw(FTS_ADDR_CTRL, FTS_SP_ROOT, 32'h0000_0000, 4'h1);
    axr(FTS_ADDR_CTRL, FTS_SP_ROOT);
    `CHK("ctrl lane0", 32'h0000_C000, rd)
    axw(FTS_ADDR_CTRL, FTS_SP_ROOT, 32'h0000_00FF, 4'h2);
    axr(FTS_ADDR_CTRL, FTS_SP_ROOT);
    `CHK("ctrl lane1", 32'h0000_0000, rd)
    axw(FTS_ADDR_CTRL, FTS_SP_ROOT, 32'hFFFF_FFFF);
    $display("test regs done");
  endtask

  task automatic t_access();
    for (int p = 0; p < 4; p++) begin
      if (2'(p) == FTS_SP_ROOT) continue;
      axw(FTS_ADDR_CTRL, 2'(p), 32'h0000_0000);
      `CHK("wr resp", FTS_RESP_SLVERR, resp)
      axr(FTS_ADDR_CTRL, 2'(p));
      `CHK("rd resp", FTS_RESP_SLVERR, resp)
      `CHK("rd data", 32'h0000_0000, rd)
    end
    axr(FTS_ADDR_CTRL, FTS_SP_ROOT);
    `CHK("ctrl kept", 32'h0000_C0C0, rd)
    axw(12'h00C, FTS_SP_ROOT, 32'h0000_0000);
    `CHK("unmapped wr", FTS_RESP_DECERR, resp)
    axr(12'h00C, FTS_SP_ROOT);
    `CHK("unmapped rd", FTS_RESP_DECERR, resp)
    $display("test access done");
  endtask

  task automatic check_fwd(input int l, input logic [15:0] c);
    logic [1:0] e;
    e = exp_map(2'(l), c);
    if (!e[0]) exp_mon++;
    `CHK("fwd valid", 1'b1, fwd_valid)
    `CHK("ns label", e[1], request_nonsecure_label)
    `CHK("suppress", e[0], suppress_monitor_flag)
    `CHK("pas", 2'(l) ^ 2'h1, fwd_pas)
    `CHK("pid", 16'hA5C0 + 16'(l), fwd_partition_identifier)
    `CHK("pmg", 8'h3C + 8'(l), fwd_pmg)
    `CHK("fixed label", l[0], fx_ns)
    `CHK("fixed flag", 1'b0, fx_flag)
    `CHK("np pid", 16'h0000, np_pid)
    `CHK("np pmg", 8'h00, np_pmg)
    `CHK("np flag", 1'b0, np_flag)
  endtask

  // Back-to-back requests, each checked just after the edge that registers it
  task automatic t_map();
    logic [15:0] cfg [6] = '{16'h0000, 16'hC000, 16'h00C0, 16'h8040, 16'h4080, 16'hC0C0};
    for (int c = 0; c < 6; c++) begin
      axw(FTS_ADDR_CTRL, FTS_SP_ROOT, {16'h0000, cfg[c]});
      for (int l = 0; l < 5; l++) begin
        @(posedge clock);
        req_valid <= (l < 4);
        request_space_label <= 2'(l);
        req_pas <= 2'(l) ^ 2'h1;
        req_partition_identifier <= 16'hA5C0 + 16'(l);
        req_pmg <= 8'h3C + 8'(l);
        #1;
        if (l > 0) check_fwd(l - 1, cfg[c]);
      end
      @(posedge clock);
      #1;
      `CHK("idle valid", 1'b0, fwd_valid)
      `CHK("idle flag", 1'b0, suppress_monitor_flag)
    end
    `CHK("seen", 32'h0000_0018, n_seen)
    `CHK("monitored", exp_mon, n_monitored)
    axw(FTS_ADDR_REMAP_CNT, FTS_SP_ROOT, 32'h0000_0000);
    `CHK("cnt wr resp", FTS_RESP_OKAY, resp)
    axr(FTS_ADDR_REMAP_CNT, FTS_SP_ROOT);
    `CHK("remap cnt", 32'h0000_000C, rd)
    axr(FTS_ADDR_SUPPR_CNT, FTS_SP_ROOT);
    `CHK("suppr cnt", 32'(24 - exp_mon), rd)
    axr(FTS_ADDR_SUPPR_CNT, FTS_SP_SECURE);
    `CHK("cnt rd hidden", 32'h0000_0000, rd)
    $display("test map done");
  endtask

  initial begin
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_awpas = 2'h0;
    s_axi_arpas = 2'h0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'h0;
    req_valid = 1'b0;
    request_space_label = 2'h0;
    req_pas = 2'h0;
    req_partition_identifier = 16'h0000;
    req_pmg = 8'h00;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_regs();
    t_access();
    t_map();
    summarize();
  end
endmodule
